// File: hw/iofs_debounce.sv
// Debounce filter for one discrete input
`timescale 1ns/1ns
module iofs_debounce #(
    parameter int unsigned STABLE = iofs_pkg::DEB_CYC
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Filter
    input wire logic raw,
    input wire logic enable,
    output logic clean
);
    import iofs_pkg::*;
    typedef struct packed {
        logic clean;
        logic [19:0] cnt;
    } iofs_deb_t;
    localparam logic [19:0] LIM = 20'(STABLE - 1);
    iofs_deb_t s_reg, s_next;

    always_comb
    begin
        s_next = s_reg;
        if (!enable || raw == s_reg.clean)
        begin
            s_next.clean = raw;
            s_next.cnt = '0;
        end
        else if (s_reg.cnt == LIM)
        begin
            // Only a level held for the full window counts [R12]
            s_next.clean = raw;
            s_next.cnt = '0;
        end
        else
        begin
            s_next.cnt = s_reg.cnt + 20'h00001;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
            s_reg <= '0;
        else
            s_reg <= s_next;
    end

    assign clean = s_reg.clean;

    deb_hold_a: assert property (@(posedge ref_clk) disable iff (reset) // [R12]
        enable && s_reg.cnt != LIM |=> clean == $past(clean))
        else $error("debounced level moved before window");
endmodule

// File: hw/iofs_delta.sv
// Change-threshold report filter for one analog input
`timescale 1ns/1ns
module iofs_delta (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Sample in
    input wire logic valid,
    input wire logic [15:0] sample,
    input wire logic [15:0] delta,
    input wire logic freeze,
    // Report out
    output logic [15:0] value,
    output logic report
);
    import iofs_pkg::*;
    typedef struct packed {
        logic [15:0] value;
        logic report;
    } iofs_dlt_t;
    iofs_dlt_t s_reg, s_next;
    logic [15:0] diff;

    assign diff = (sample >= s_reg.value) ? sample - s_reg.value
                                          : s_reg.value - sample;

    always_comb
    begin
        s_next = s_reg;
        s_next.report = 1'b0;
        // Zero delta passes every valid sample unless frozen [R11]
        if (valid && !freeze && (delta == 16'h0000 || diff >= delta)) // [R10]
        begin
            s_next.value = sample;
            s_next.report = 1'b1;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
            s_reg <= '0;
        else
            s_reg <= s_next;
    end

    assign value = s_reg.value;
    assign report = s_reg.report;

    dlt_gate_a: assert property (@(posedge ref_clk) disable iff (reset) // [R10]
        valid && !freeze && delta != 16'h0000 && diff < delta |=> !report)
        else $error("report below delta");
    dlt_zero_a: assert property (@(posedge ref_clk) disable iff (reset) // [R11]
        valid && !freeze && delta == 16'h0000 |=> report && value == $past(sample))
        else $error("zero delta did not report");
endmodule

// File: hw/iofs_pkg.sv
// Package: constants and types of the fail-safe I/O conditioning block
package iofs_pkg;
    localparam int unsigned CLK_MHZ = 100;
    localparam int unsigned HOST_TO_MS = 4000;
    localparam int unsigned HOST_TO_CYC = HOST_TO_MS * 1000 * CLK_MHZ;
    localparam int unsigned DEB_US = 10000;
    localparam int unsigned DEB_CYC = DEB_US * CLK_MHZ;
    localparam int unsigned NDIN = 8;
    localparam int unsigned NDOUT = 8;
    localparam int unsigned NAIN = 2;
    localparam int unsigned NAOUT = 2;
    localparam int unsigned AW = 16;
    localparam int unsigned NIRQ = 6;
    // Byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_COND = 8'h04;
    localparam logic [7:0] OFS_DOUT = 8'h08;
    localparam logic [7:0] OFS_DOUT_DEF = 8'h0C;
    localparam logic [7:0] OFS_AOUT = 8'h10;
    localparam logic [7:0] OFS_AOUT_DEF = 8'h18;
    localparam logic [7:0] OFS_DELTA = 8'h20;
    localparam logic [7:0] OFS_POLL = 8'h24;
    localparam logic [7:0] OFS_MISS = 8'h28;
    localparam logic [7:0] OFS_RELINK = 8'h2C;
    localparam logic [7:0] OFS_DIN = 8'h30;
    localparam logic [7:0] OFS_AIN = 8'h34;
    localparam logic [7:0] OFS_IRQ_ST = 8'h3C;
    localparam logic [7:0] OFS_IRQ_CLR = 8'h40;
    localparam logic [7:0] OFS_IRQ_EN = 8'h44;
    // Control bit positions
    localparam int unsigned CB_DEB = 0;
    localparam int unsigned CB_HOST = 1;
    localparam int unsigned CB_NLF = 2;
    localparam int unsigned CB_GLF = 3;
    // Event bit positions
    localparam int unsigned EV_HOST = 0;
    localparam int unsigned EV_SYNC = 1;
    localparam int unsigned EV_NODE = 2;
    localparam int unsigned EV_GW = 3;
    localparam int unsigned EV_DIN = 4;
    localparam int unsigned EV_AIN = 5;
    // Reset values
    localparam logic [3:0] CTRL_RST = 4'h3;
    localparam logic [7:0] DOUT_DEF_RST = 8'h00;
    localparam logic [15:0] AOUT_DEF_RST = 16'h0000;
    localparam logic [15:0] DELTA_RST = 16'h0000;
    localparam logic [31:0] POLL_RST = 32'h000F4240;
    localparam logic [7:0] MISS_RST = 8'h03;
    localparam logic [7:0] RELINK_RST = 8'h02;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef logic [NAOUT-1:0][AW-1:0] iofs_aout_t;
    typedef struct packed {
        logic valid;
        logic [NAIN-1:0][AW-1:0] data;
    } iofs_ain_t;
endpackage

// File: hw/iofs_top.sv
// Fail-safe output and input conditioning with AXI4-Lite registers
//
// Decided for this implementation: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ns
// Function
// R1: After reset every output is loaded with its default before normal use.
// R2: While radio sync is lost outputs are held at their defaults.
// R3: Host link fails when no host access arrives within about four seconds.
// R4: A detected host link failure drives outputs to their defaults.
// R5: A node link failure with its option set forces defaults and freezes inputs.
// R6: Node timeout uses poll interval, missed message limit and relink count.
// R7: A timed-out node with its option set sends its outputs to defaults.
// R8: Each discrete default is one bit, one on and zero off.
// R9: A default condition copies stored defaults into the output registers.
// R10: An analog input reports only after changing by at least delta.
// R11: A delta of zero turns the change filter off.
// R12: Discrete inputs are debounced so contact bounce is one change.
// R13: Debounce is enabled after reset.
// R14: When the link returns, outputs resume normal updating.
// R15: While inputs are frozen the last valid values are reported.
module iofs_top #(
    parameter int unsigned HOST_TO = iofs_pkg::HOST_TO_CYC,
    parameter int unsigned DEB = iofs_pkg::DEB_CYC
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Radio link pins
    input wire logic radio_sync_in,
    input wire logic radio_msg_in,
    input wire logic node_reply_in,
    // Field inputs
    input wire logic [iofs_pkg::NDIN-1:0] din_in,
    input wire iofs_pkg::iofs_ain_t ain,
    // Field outputs and interrupt
    output logic [iofs_pkg::NDOUT-1:0] dout,
    output iofs_pkg::iofs_aout_t aout,
    output logic irq
);
    import iofs_pkg::*;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic aw_got;
        logic w_got;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic [3:0] ctrl;
        logic [7:0] dout;
        logic [7:0] dout_def;
        iofs_aout_t aout;
        iofs_aout_t aout_def;
        logic [15:0] delta;
        logic [31:0] poll;
        logic [7:0] miss_max;
        logic [7:0] relink;
        logic [NIRQ-1:0] irq_st;
        logic [NIRQ-1:0] irq_en;
        logic irq;
        logic [10:0] s1;
        logic [10:0] s2;
        logic [2:0] edge_prev;
        logic pwrup;
        logic [28:0] host_cnt;
        logic host_fail;
        logic [31:0] node_cnt;
        logic node_fail;
        logic [31:0] gw_cnt;
        logic gw_seen;
        logic [7:0] gw_miss;
        logic [7:0] gw_good;
        logic gw_to;
        logic [7:0] din_rep;
    } iofs_state_t;

    localparam logic [28:0] HOST_LIM = 29'(HOST_TO - 1);

    iofs_state_t s_reg, s_next;
    logic [NDIN-1:0] deb_clean;
    logic [NAIN-1:0][AW-1:0] ain_val;
    logic [NAIN-1:0] ain_rep;
    logic sync_ok, msg_rise, reply_rise, frozen, def_act, win_end, host_act_w;

    function automatic logic [31:0] merge(input logic [31:0] old,
        input logic [31:0] d, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++)
        begin
            if (be[b])
                r[8*b +: 8] = d[8*b +: 8];
        end
        return r;
    endfunction

    function automatic logic reg_ok(input logic [7:0] a);
        return a[1:0] == 2'h0 && a <= OFS_IRQ_EN;
    endfunction

    // Only the second stage feeds logic
    assign sync_ok = s_reg.s2[8];
    assign msg_rise = s_reg.s2[9] && !s_reg.edge_prev[1];
    assign reply_rise = s_reg.s2[10] && !s_reg.edge_prev[2];
    assign frozen = s_reg.node_fail && s_reg.ctrl[CB_NLF];
    assign win_end = s_reg.gw_cnt + 32'h1 >= s_reg.poll;
    assign def_act = s_reg.pwrup // [R1]
        || !sync_ok // [R2]
        || (s_reg.host_fail && s_reg.ctrl[CB_HOST]) // [R4]
        || frozen // [R5]
        || (s_reg.gw_to && s_reg.ctrl[CB_GLF]); // [R7]

    genvar gi;
    generate
        for (gi = 0; gi < NDIN; gi++)
        begin : g_deb
            iofs_debounce #(.STABLE(DEB)) u_deb (
                .ref_clk(ref_clk),
                .reset(reset),
                .raw(s_reg.s2[gi]),
                .enable(s_reg.ctrl[CB_DEB]),
                .clean(deb_clean[gi])
            );
        end
        for (gi = 0; gi < NAIN; gi++)
        begin : g_dlt
            iofs_delta u_dlt (
                .ref_clk(ref_clk),
                .reset(reset),
                .valid(ain.valid),
                .sample(ain.data[gi]),
                .delta(s_reg.delta),
                .freeze(frozen), // [R15]
                .value(ain_val[gi]),
                .report(ain_rep[gi])
            );
        end
    endgenerate

    always_comb
    begin
        logic [31:0] rd;
        logic [NIRQ-1:0] ev;
        rd = '0;
        ev = '0;
        s_next = s_reg;
        s_next.s1 = {node_reply_in, radio_msg_in, radio_sync_in, din_in};
        s_next.s2 = s_reg.s1;
        s_next.edge_prev = s_reg.s2[10:8];
        s_next.pwrup = 1'b0;
        if (s_axi_awvalid && s_reg.awready)
        begin
            s_next.aw_got = 1'b1;
            s_next.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_reg.wready)
        begin
            s_next.w_got = 1'b1;
            s_next.wdata = s_axi_wdata;
            s_next.wstrb = s_axi_wstrb;
        end
        if (s_reg.bvalid && s_axi_bready)
            s_next.bvalid = 1'b0;
        if (s_reg.aw_got && s_reg.w_got && !s_reg.bvalid)
        begin
            s_next.aw_got = 1'b0;
            s_next.w_got = 1'b0;
            s_next.bvalid = 1'b1;
            s_next.bresp = reg_ok(s_reg.awaddr) ? RESP_OKAY : RESP_SLVERR;
            unique case (s_reg.awaddr)
                OFS_CTRL: s_next.ctrl =
                    4'(merge(32'(s_reg.ctrl), s_reg.wdata, s_reg.wstrb));
                OFS_DOUT: s_next.dout =
                    8'(merge(32'(s_reg.dout), s_reg.wdata, s_reg.wstrb));
                OFS_DOUT_DEF: s_next.dout_def = // [R8]
                    8'(merge(32'(s_reg.dout_def), s_reg.wdata, s_reg.wstrb));
                OFS_DELTA: s_next.delta =
                    16'(merge(32'(s_reg.delta), s_reg.wdata, s_reg.wstrb));
                OFS_POLL: s_next.poll =
                    merge(s_reg.poll, s_reg.wdata, s_reg.wstrb);
                OFS_MISS: s_next.miss_max =
                    8'(merge(32'(s_reg.miss_max), s_reg.wdata, s_reg.wstrb));
                OFS_RELINK: s_next.relink =
                    8'(merge(32'(s_reg.relink), s_reg.wdata, s_reg.wstrb));
                OFS_IRQ_EN: s_next.irq_en = NIRQ'(
                    merge(32'(s_reg.irq_en), s_reg.wdata, s_reg.wstrb));
                default: ;
            endcase
            for (int i = 0; i < NAOUT; i++)
            begin
                if (s_reg.awaddr == OFS_AOUT + 8'(4 * i))
                    s_next.aout[i] = 16'(merge(32'(s_reg.aout[i]),
                        s_reg.wdata, s_reg.wstrb));
                if (s_reg.awaddr == OFS_AOUT_DEF + 8'(4 * i))
                    s_next.aout_def[i] = 16'(merge(32'(s_reg.aout_def[i]),
                        s_reg.wdata, s_reg.wstrb));
            end
        end
        // Read path
        unique case (s_axi_araddr)
            OFS_CTRL: rd = 32'(s_reg.ctrl);
            OFS_COND: rd = 32'({frozen, s_reg.gw_to, s_reg.node_fail,
                s_reg.host_fail, !sync_ok, def_act});
            OFS_DOUT: rd = 32'(s_reg.dout);
            OFS_DOUT_DEF: rd = 32'(s_reg.dout_def);
            OFS_DELTA: rd = 32'(s_reg.delta);
            OFS_POLL: rd = s_reg.poll;
            OFS_MISS: rd = 32'(s_reg.miss_max);
            OFS_RELINK: rd = 32'(s_reg.relink);
            OFS_DIN: rd = 32'(s_reg.din_rep);
            OFS_IRQ_ST: rd = 32'(s_reg.irq_st);
            OFS_IRQ_EN: rd = 32'(s_reg.irq_en);
            default: rd = '0;
        endcase
        for (int i = 0; i < NAOUT; i++)
        begin
            if (s_axi_araddr == OFS_AOUT + 8'(4 * i))
                rd = 32'(s_reg.aout[i]);
            if (s_axi_araddr == OFS_AOUT_DEF + 8'(4 * i))
                rd = 32'(s_reg.aout_def[i]);
        end
        for (int i = 0; i < NAIN; i++)
        begin
            if (s_axi_araddr == OFS_AIN + 8'(4 * i))
                rd = 32'(ain_val[i]);
        end
        if (s_axi_arvalid && s_reg.arready)
        begin
            s_next.rvalid = 1'b1;
            s_next.rdata = rd;
            s_next.rresp = reg_ok(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_reg.rvalid && s_axi_rready)
        begin
            s_next.rvalid = 1'b0;
        end
        s_next.awready = !s_next.aw_got && !s_next.bvalid;
        s_next.wready = !s_next.w_got && !s_next.bvalid;
        s_next.arready = !s_next.rvalid;
        // Host watchdog; any accepted write or read address handshake counts as host traffic
        if (!s_reg.ctrl[CB_HOST] || host_act_w)
        begin
            s_next.host_cnt = '0;
            s_next.host_fail = 1'b0; // [R14]
        end
        else if (s_reg.host_cnt == HOST_LIM)
        begin
            s_next.host_fail = 1'b1; // [R3]
        end
        else
        begin
            s_next.host_cnt = s_reg.host_cnt + 29'h1;
        end
        // Node side: gateway silence or sync loss [R5]
        if (msg_rise)
            s_next.node_cnt = '0;
        else if (s_reg.node_cnt != 32'hFFFFFFFF)
            s_next.node_cnt = s_reg.node_cnt + 32'h1;
        if (!sync_ok || (s_reg.node_cnt >= s_reg.poll && !msg_rise))
            s_next.node_fail = 1'b1;
        else if (msg_rise)
            s_next.node_fail = 1'b0; // [R14]
        // Gateway side: missed polls and relink count [R6]
        if (reply_rise)
            s_next.gw_seen = 1'b1;
        if (win_end)
        begin
            s_next.gw_cnt = '0;
            s_next.gw_seen = 1'b0;
            if (s_reg.gw_seen || reply_rise)
            begin
                s_next.gw_miss = '0;
                s_next.gw_good = s_reg.gw_good + 8'h1;
                if (s_reg.gw_good + 8'h1 >= s_reg.relink)
                begin
                    s_next.gw_to = 1'b0; // [R14]
                    s_next.gw_good = '0;
                end
            end
            else
            begin
                s_next.gw_good = '0;
                if (s_reg.gw_miss != 8'hFF)
                    s_next.gw_miss = s_reg.gw_miss + 8'h1;
                if (s_reg.gw_miss + 8'h1 >= s_reg.miss_max)
                    s_next.gw_to = 1'b1;
            end
        end
        else
        begin
            s_next.gw_cnt = s_reg.gw_cnt + 32'h1;
        end
        // Frozen inputs keep the last valid values [R15]
        if (!frozen)
            s_next.din_rep = deb_clean;
        // Stored defaults overwrite the output registers [R9]
        if (def_act)
        begin
            s_next.dout = s_reg.dout_def; // [R8]
            s_next.aout = s_reg.aout_def;
        end
        // Events; a set beats a same-cycle clear
        ev[EV_HOST] = s_next.host_fail && !s_reg.host_fail;
        // Edge taken on the second stage only, never the first
        ev[EV_SYNC] = s_reg.edge_prev[0] && !sync_ok;
        ev[EV_NODE] = s_next.node_fail && !s_reg.node_fail;
        ev[EV_GW] = s_next.gw_to && !s_reg.gw_to;
        ev[EV_DIN] = s_next.din_rep != s_reg.din_rep;
        ev[EV_AIN] = |ain_rep;
        if (s_reg.aw_got && s_reg.w_got && !s_reg.bvalid
            && s_reg.awaddr == OFS_IRQ_CLR)
            s_next.irq_st = s_reg.irq_st & ~NIRQ'(s_reg.wdata);
        s_next.irq_st = s_next.irq_st | ev;
        s_next.irq = |(s_next.irq_st & s_next.irq_en);
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            s_reg <= '0;
            s_reg.ctrl <= CTRL_RST; // [R13]
            s_reg.dout <= DOUT_DEF_RST; // [R1]
            s_reg.dout_def <= DOUT_DEF_RST;
            s_reg.aout <= {NAOUT{AOUT_DEF_RST}};
            s_reg.aout_def <= {NAOUT{AOUT_DEF_RST}};
            s_reg.delta <= DELTA_RST;
            s_reg.poll <= POLL_RST;
            s_reg.miss_max <= MISS_RST;
            s_reg.relink <= RELINK_RST;
            s_reg.pwrup <= 1'b1;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign s_axi_awready = s_reg.awready;
    assign s_axi_wready = s_reg.wready;
    assign s_axi_bvalid = s_reg.bvalid;
    assign s_axi_bresp = s_reg.bresp;
    assign s_axi_arready = s_reg.arready;
    assign s_axi_rvalid = s_reg.rvalid;
    assign s_axi_rresp = s_reg.rresp;
    assign s_axi_rdata = s_reg.rdata;
    assign dout = s_reg.dout;
    assign aout = s_reg.aout;
    assign irq = s_reg.irq;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);

    pwrup_default_a: assert property (s_reg.pwrup // [R1]
        |=> dout == $past(s_reg.dout_def) && aout == $past(s_reg.aout_def))
        else $error("power-up default not loaded");
    sync_default_a: assert property (!sync_ok // [R2]
        |=> dout == $past(s_reg.dout_def) && aout == $past(s_reg.aout_def))
        else $error("sync loss did not hold defaults");
    host_timeout_a: assert property (s_reg.ctrl[CB_HOST] // [R3]
        && !host_act_w && s_reg.host_cnt == HOST_LIM |=> s_reg.host_fail)
        else $error("host timeout missed");
    host_default_a: assert property (s_reg.host_fail // [R4]
        && s_reg.ctrl[CB_HOST] |=> dout == $past(s_reg.dout_def))
        else $error("host failure did not default outputs");
    node_default_a: assert property (frozen // [R5]
        |=> dout == $past(s_reg.dout_def))
        else $error("node failure did not default outputs");
    gw_timeout_a: assert property (win_end && !s_reg.gw_seen // [R6]
        && !reply_rise && s_reg.gw_miss + 8'h1 >= s_reg.miss_max
        |=> s_reg.gw_to)
        else $error("node timeout not declared");
    gw_default_a: assert property (s_reg.gw_to && s_reg.ctrl[CB_GLF] // [R7]
        |=> aout == $past(s_reg.aout_def))
        else $error("timed-out node outputs not defaulted");
    relink_a: assert property (s_reg.gw_to && win_end // [R14]
        && s_reg.gw_seen && s_reg.gw_good + 8'h1 >= s_reg.relink
        |=> !s_reg.gw_to)
        else $error("relink did not restore");
    freeze_hold_a: assert property (frozen // [R15]
        |=> s_reg.din_rep == $past(s_reg.din_rep))
        else $error("frozen inputs changed");
    deb_on_a: assert property (s_reg.pwrup |-> s_reg.ctrl[CB_DEB]) // [R13]
        else $error("debounce off after reset");

    assign host_act_w = (s_axi_awvalid && s_reg.awready)
        || (s_axi_arvalid && s_reg.arready);

    host_fail_c: cover property (s_reg.host_fail);
    relink_c: cover property (s_reg.gw_to ##[1:1000] !s_reg.gw_to);
    frozen_c: cover property (frozen);
    irq_c: cover property (irq);
endmodule

// File: hw/iofs_top_fix.sv
// Reserved file; holds no logic

// File: testbench/io_failsafe_output_conditioning_tb.sv
// Self-checking bench for the fail-safe I/O conditioning block
`timescale 1ns/1ns
module io_failsafe_output_conditioning_tb;
    import iofs_pkg::*;
    logic ref_clk = 0, reset = 1, sync_on = 1, reply_on = 1;
    logic [7:0] awaddr = 0, araddr = 0, din = 0, dout;
    logic [31:0] wdata = 0, rd, rdata;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic radio_sync_in, radio_msg_in, node_reply_in, irq, bvalid, rvalid;
    logic awready, wready, arready;
    logic [1:0] bresp, rresp, rs;
    iofs_ain_t ain = '0;
    iofs_aout_t aout;
    int errors = 0, checks = 0, seed = 96881, n, last = 0, s, d, i;
    always #5 ref_clk = ~ref_clk;
    iofs_radio_model iofs_radio_model_inst (.ref_clk(ref_clk),
        .sync_on(sync_on), .reply_on(reply_on),
        .radio_sync_in(radio_sync_in),
        .radio_msg_in(radio_msg_in), .node_reply_in(node_reply_in));
    iofs_top #(.HOST_TO(50), .DEB(4)) iofs_top_inst (.ref_clk(ref_clk),
        .reset(reset), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .radio_sync_in(radio_sync_in),
        .radio_msg_in(radio_msg_in), .node_reply_in(node_reply_in),
        .din_in(din), .ain(ain), .dout(dout), .aout(aout), .irq(irq));
    task report_and_stop;
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task lim;
        if (n >= 50)
        begin
            errors++;
            report_and_stop;
        end
    endtask
    task chk(input string nm, input logic [31:0] seen, exp);
        checks++;
        if (seen !== exp)
        begin
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
            errors++;
        end
    endtask
    // Ready is judged at the falling edge so the handshake edge is known
    task wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge ref_clk);
        awaddr <= a;
        wdata <= v;
        {awvalid, wvalid, bready} <= 3'h7;
        n = 0;
        do @(negedge ref_clk); while ((awready & wready) !== 1'b1 && ++n < 50);
        lim;
        @(posedge ref_clk);
        {awvalid, wvalid} <= 2'h0;
        n = 0;
        do @(negedge ref_clk); while (bvalid !== 1'b1 && ++n < 50);
        lim;
        @(posedge ref_clk);
        bready <= 0;
    endtask
    task rdt(input logic [7:0] a);
        @(posedge ref_clk);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        n = 0;
        do @(negedge ref_clk); while (arready !== 1'b1 && ++n < 50);
        lim;
        @(posedge ref_clk);
        arvalid <= 0;
        n = 0;
        do @(negedge ref_clk); while (rvalid !== 1'b1 && ++n < 50);
        lim;
        rd = rdata;
        rs = rresp;
        @(posedge ref_clk);
        rready <= 0;
    endtask
    initial
    begin
        repeat (8) @(posedge ref_clk);
        reset <= 0;
        rdt(OFS_CTRL);
        chk("ctrl", rd[3:0], CTRL_RST);
        chk("dout", dout, DOUT_DEF_RST);
        wr(OFS_CTRL, 32'h1);
        wr(OFS_DOUT_DEF, 32'hA5);
        wr(OFS_AOUT_DEF, 32'h1234);
        wr(OFS_DOUT, 32'h3C);
        wr(OFS_AOUT, 32'hABC);
        wr(OFS_IRQ_EN, 32'h2);
        chk("dout", dout, 8'h3C);
        chk("aout", aout[0], 16'hABC);
        wr(OFS_CTRL, 32'h5);
        sync_on <= 0;
        din <= 8'h80;
        repeat (12) @(posedge ref_clk);
        chk("dout", dout, 8'hA5);
        chk("aout", aout[0], 16'h1234);
        chk("irq", irq, 1);
        rdt(OFS_DIN);
        chk("din", rd[7:0], 8'h00);
        sync_on <= 1;
        din <= 8'h00;
        repeat (30) @(posedge ref_clk);
        // Defaults stay in the output register until rewritten
        chk("dout", dout, 8'hA5);
        wr(OFS_DOUT, 32'h3C);
        chk("dout", dout, 8'h3C);
        wr(OFS_IRQ_CLR, 32'h2);
        repeat (2) @(posedge ref_clk);
        chk("irq", irq, 0);
        wr(OFS_CTRL, 32'h3);
        repeat (60) @(posedge ref_clk);
        chk("dout", dout, 8'hA5);
        wr(OFS_CTRL, 32'h9);
        wr(OFS_POLL, 32'h10);
        wr(OFS_DOUT, 32'h3C);
        chk("dout", dout, 8'h3C);
        reply_on <= 0;
        repeat (80) @(posedge ref_clk);
        chk("dout", dout, 8'hA5);
        reply_on <= 1;
        repeat (60) @(posedge ref_clk);
        wr(OFS_DOUT, 32'h3C);
        chk("dout", dout, 8'h3C);
        wr(OFS_DELTA, 32'h10);
        for (i = 0; i < 12; i++)
        begin
            d = (i < 8) ? 16 : 0;
            if (i == 8)
                wr(OFS_DELTA, 32'h0);
            s = $random(seed) & 32'h1F;
            @(posedge ref_clk);
            ain <= {1'b1, 16'h0, s[15:0]};
            @(posedge ref_clk);
            ain.valid <= 0;
            if (d == 0 || s - last >= d || last - s >= d)
                last = s;
            rdt(OFS_AIN);
            chk("ain", rd[15:0], last[15:0]);
        end
        wr(OFS_IRQ_CLR, 32'h3F);
        // Pulses shorter than the filter span must not show through
        for (i = 0; i < 5; i++)
        begin
            @(posedge ref_clk);
            din <= {7'h0, i[0]};
        end
        repeat (12) @(posedge ref_clk);
        rdt(OFS_IRQ_ST);
        chk("din_event", rd[EV_DIN], 0);
        din <= 8'h01;
        repeat (12) @(posedge ref_clk);
        rdt(OFS_DIN);
        chk("din", rd[7:0], 8'h01);
        rdt(8'h48);
        chk("resp", rs, RESP_SLVERR);
        report_and_stop;
    end
endmodule

// File: testbench/iofs_radio_model.sv
// Far-side model: parent radio and one remote node
`timescale 1ns/1ns
module iofs_radio_model (
    // Clock and control
    input wire logic ref_clk,
    input wire logic sync_on,
    input wire logic reply_on,
    // Radio pins
    output logic radio_sync_in = 1'b0,
    output logic radio_msg_in = 1'b0,
    output logic node_reply_in = 1'b0
);
    logic [2:0] cnt = 3'h0;
    always @(posedge ref_clk)
    begin
        cnt <= cnt + 3'h1;
        radio_sync_in <= sync_on;
        // Traffic stops while out of sync, as a real parent would
        radio_msg_in <= sync_on && cnt == 3'h0;
        node_reply_in <= sync_on && reply_on && cnt == 3'h4;
    end
endmodule
